// >>> damr_defs.vh
// Constants shared by the damper actuator Modbus register block
`ifndef DAMR_DEFS_VH
`define DAMR_DEFS_VH
// Function codes
`define DAMR_FC_RD_BITS 8'h02
`define DAMR_FC_RD_HOLD 8'h03
`define DAMR_FC_RD_INPUT 8'h04
`define DAMR_FC_WR_SINGLE 8'h06
// Exception answers
`define DAMR_EXC_NONE 8'h00
`define DAMR_EXC_FUNC 8'h01
`define DAMR_EXC_ADDR 8'h02
`define DAMR_EXC_VALUE 8'h03
`define DAMR_EXC_FLAG 8'h80
`define DAMR_BCAST 8'h00
// Table addresses (zero based)
`define DAMR_A_SETPT 16'h0000
`define DAMR_A_OVR 16'h0001
`define DAMR_A_CMD 16'h0002
`define DAMR_A_TYPE 16'h0003
`define DAMR_A_POS_REL 16'h0004
`define DAMR_A_POS_ABS 16'h0005
`define DAMR_A_FLOW_REL 16'h0006
`define DAMR_A_FLOW_ABS 16'h0007
`define DAMR_A_SENSOR 16'h0008
`define DAMR_A_SER1 16'h0064
`define DAMR_A_SER2 16'h0065
`define DAMR_A_SER4 16'h0066
`define DAMR_A_FW 16'h0067
`define DAMR_A_FLAGS 16'h0068
`define DAMR_A_LOWER 16'h0069
`define DAMR_A_UPPER 16'h006a
`define DAMR_A_SKIND 16'h006b
`define DAMR_A_FAIL 16'h006c
// Discrete input window onto the fault flags
`define DAMR_BIT_BASE 16'h0680
`define DAMR_BIT_END 16'h0690
`define DAMR_BIT_MAXQ 16'h0010
// Values
`define DAMR_FULL 16'h2710
`define DAMR_OVR_NONE 16'h0000
`define DAMR_OVR_OPEN 16'h0001
`define DAMR_OVR_CLOSE 16'h0002
`define DAMR_OVR_MIN 16'h0003
`define DAMR_OVR_MAX 16'h0005
`define DAMR_CMD_MAX 16'h0004
`define DAMR_MAX_QTY 16'h007d
`define DAMR_REQ_LEN 4'h8
`define DAMR_CRC_INIT 16'hffff
`define DAMR_CRC_POLY 16'ha001
// Serial timing in oversampling ticks
`define DAMR_OVS 8
`define DAMR_PH_MID 3'h3
`define DAMR_PH_LAST 3'h7
`define DAMR_BIT_STOP 4'h9
`define DAMR_GAP_TICKS 9'h118
`endif

// >>> damr_uart_rx.v
// Serial receiver, 8N1, eight ticks per bit, filtered input
`include "damr_defs.vh"
module damr_uart_rx (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   input wire tick_i,
   // Line
   input wire rx_i,
   // Received byte
   output reg [7:0] data_o,
   output reg valid_o,
   output reg busy_o
);
   reg s1_q, s2_q, s3_q, line_q;
   reg [2:0] ph_q;
   reg [3:0] bitn_q;
   reg [7:0] sh_q;
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         line_q <= 1'b1;
         ph_q <= 3'h0;
         bitn_q <= 4'h0;
         sh_q <= 8'h00;
         data_o <= 8'h00;
         valid_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else
      begin
         s1_q <= rx_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Level only trusted once two stages agree
         if (s2_q == s3_q)
            line_q <= s2_q;
         valid_o <= 1'b0;
         if (!busy_o)
         begin
            if (!line_q)
            begin
               busy_o <= 1'b1;
               ph_q <= 3'h0;
               bitn_q <= 4'h0;
            end
         end
         else if (tick_i)
         begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == `DAMR_PH_MID)
            begin
               bitn_q <= bitn_q + 4'h1;
               if (bitn_q == 4'h0)
               begin
                  if (line_q)
                     busy_o <= 1'b0;
               end
               else if (bitn_q == `DAMR_BIT_STOP)
               begin
                  // Framing error drops the byte
                  busy_o <= 1'b0;
                  valid_o <= line_q;
                  data_o <= sh_q;
               end
               else
                  sh_q <= {line_q, sh_q[7:1]};
            end
         end
      end
   end
endmodule

// >>> damr_uart_tx.v
// Serial transmitter, 8N1, eight ticks per bit
`include "damr_defs.vh"
module damr_uart_tx (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   input wire tick_i,
   // Byte to send
   input wire start_i,
   input wire [7:0] data_i,
   // Line
   output reg tx_o,
   output reg busy_o
);
   reg [2:0] ph_q;
   reg [3:0] bitn_q;
   reg [8:0] sh_q;
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_o <= 1'b1;
         busy_o <= 1'b0;
         ph_q <= 3'h0;
         bitn_q <= 4'h0;
         sh_q <= 9'h1ff;
      end
      else if (!busy_o)
      begin
         if (start_i)
         begin
            tx_o <= 1'b0;
            busy_o <= 1'b1;
            sh_q <= {1'b1, data_i};
            ph_q <= 3'h0;
            bitn_q <= 4'h0;
         end
      end
      else if (tick_i)
      begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == `DAMR_PH_LAST)
         begin
            if (bitn_q == `DAMR_BIT_STOP)
               busy_o <= 1'b0;
            else
            begin
               tx_o <= sh_q[0];
               sh_q <= {1'b1, sh_q[8:1]};
               bitn_q <= bitn_q + 4'h1;
            end
         end
      end
   end
endmodule

// >>> damr_modbus_regs.v
// Modbus RTU register table and positioning control of a damper actuator
`include "damr_defs.vh"
module damr_modbus_regs #(
   parameter CLK_HZ = 100000000,
   parameter BAUD = 19200,
   // Identity values below are arbitrary
   parameter [15:0] SER_PART1 = 16'h1111,
   parameter [15:0] SER_PART2 = 16'h2222,
   parameter [15:0] SER_PART4 = 16'h4444,
   parameter [15:0] FW_VERSION = 16'h0101
) (
   // Clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // RS-485 line
   input wire RS485_RX_I,
   output reg RS485_TX_O,
   output reg RS485_DRV_N_O,
   input wire [7:0] SLAVE_ADDR_I,
   // Mechanics pins
   input wire DIR_SWITCH_I,
   input wire GEAR_RELEASE_I,
   input wire END_STOP_I,
   // Live values
   input wire [15:0] ACT_TYPE_I,
   input wire [15:0] POS_REL_I,
   input wire [15:0] POS_ABS_I,
   input wire [15:0] FLOW_REL_I,
   input wire [15:0] FLOW_ABS_I,
   input wire [15:0] SENSOR_I,
   input wire [15:0] FAULT_FLAGS_I,
   input wire CMD_DONE_I,
   // Positioning
   output reg HOMING_O,
   output reg HOME_CW_O,
   output reg [15:0] TARGET_O,
   output reg TARGET_VALID_O,
   output reg [15:0] SERVICE_CMD_O,
   output reg [15:0] SENSOR_KIND_O,
   output reg [15:0] FAIL_POS_O,
   // Non-volatile store
   output reg NV_STORE_O,
   output reg [1:0] NV_STORE_IDX_O,
   output reg [15:0] NV_STORE_DATA_O,
   input wire NV_LOAD_I,
   input wire [1:0] NV_LOAD_IDX_I,
   input wire [15:0] NV_LOAD_DATA_I
);
   localparam integer TDIV_W = CLK_HZ / (BAUD * `DAMR_OVS);
   localparam [15:0] TDIV = TDIV_W[15:0];
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_SEND = 2'h1;
   localparam [1:0] S_DRAIN = 2'h2;

   function [15:0] crc_upd;
      input [15:0] c;
      input [7:0] d;
      integer k;
      reg [15:0] x;
      begin
         x = c ^ {8'h00, d};
         for (k = 0; k < 8; k = k + 1)
            x = x[0] ? ((x >> 1) ^ `DAMR_CRC_POLY) : (x >> 1);
         crc_upd = x;
      end
   endfunction

   reg [15:0] div_q;
   reg tick_q;
   wire [7:0] rx_data;
   wire rx_valid, rx_busy, tx_line, tx_busy;
   reg [63:0] buf_q;
   reg [3:0] cnt_q;
   reg [15:0] rcrc_q, tcrc_q;
   reg [8:0] gap_q;
   reg [1:0] st_q;
   reg [7:0] idx_q, len_q, exc_q;
   reg [15:0] bits_q;
   reg tx_start_q;
   reg [7:0] tx_byte_q;
   reg [15:0] setpt_q, ovr_q, lower_q, upper_q;
   reg follow_q, gear_prev_q;
   reg [2:0] s1_q, s2_q, s3_q, pin_q;

   // Pin synchronisers, one per mechanics input
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : pin_sync
         always @(posedge CLK_I or negedge RESET_N_I)
         begin
            if (!RESET_N_I)
            begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end
            else
            begin
               s1_q[g] <= (g == 0) ? DIR_SWITCH_I :
                  (g == 1) ? GEAR_RELEASE_I : END_STOP_I;
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  pin_q[g] <= s2_q[g];
            end
         end
      end
   endgenerate

   damr_uart_rx u_rx (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .tick_i(tick_q),
      .rx_i(RS485_RX_I),
      .data_o(rx_data),
      .valid_o(rx_valid),
      .busy_o(rx_busy)
   );
   damr_uart_tx u_tx (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .tick_i(tick_q),
      .start_i(tx_start_q),
      .data_i(tx_byte_q),
      .tx_o(tx_line),
      .busy_o(tx_busy)
   );

   // Request fields; addresses are zero based on the wire
   wire [7:0] q_addr = buf_q[63:56];
   wire [7:0] q_fc = buf_q[55:48];
   wire [15:0] q_start = buf_q[47:32];
   wire [15:0] q_val = buf_q[31:16];
   wire [15:0] q_end = q_start + q_val - 16'h0001;
   wire fend = tick_q && (gap_q == `DAMR_GAP_TICKS - 9'h001) && !rx_busy;
   wire [15:0] bit_off = q_start - `DAMR_BIT_BASE;
   wire [16:0] bit_mask = (17'h00001 << q_val[4:0]) - 17'h00001;

   // Request check and exception code
   reg [7:0] exc_c;
   reg wr_ok_c;
   always @*
   begin
      exc_c = `DAMR_EXC_NONE;
      wr_ok_c = 1'b0;
      case (q_fc)
         // Holding and input register reads share one table
         `DAMR_FC_RD_HOLD, `DAMR_FC_RD_INPUT:
         begin
            if (q_val == 16'h0000 || q_val > `DAMR_MAX_QTY)
               exc_c = `DAMR_EXC_VALUE;
            else if (!((q_start <= `DAMR_A_SENSOR &&
               q_end <= `DAMR_A_SENSOR) || (q_start >= `DAMR_A_SER1 &&
               q_start <= `DAMR_A_FAIL && q_end <= `DAMR_A_FAIL)))
               exc_c = `DAMR_EXC_ADDR;
         end
         `DAMR_FC_RD_BITS:
         begin
            if (q_val == 16'h0000 || q_val > `DAMR_BIT_MAXQ)
               exc_c = `DAMR_EXC_VALUE;
            else if (q_start < `DAMR_BIT_BASE ||
               q_start + q_val > `DAMR_BIT_END)
               exc_c = `DAMR_EXC_ADDR;
         end
         `DAMR_FC_WR_SINGLE:
         begin
            case (q_start)
               `DAMR_A_SETPT, `DAMR_A_LOWER, `DAMR_A_UPPER:
                  exc_c = (q_val > `DAMR_FULL) ? `DAMR_EXC_VALUE :
                     `DAMR_EXC_NONE;
               `DAMR_A_OVR:
                  exc_c = (q_val == `DAMR_OVR_NONE ||
                     q_val == `DAMR_OVR_OPEN || q_val == `DAMR_OVR_CLOSE ||
                     q_val == `DAMR_OVR_MIN || q_val == `DAMR_OVR_MAX) ?
                     `DAMR_EXC_NONE : `DAMR_EXC_VALUE;
               `DAMR_A_CMD:
                  exc_c = (q_val > `DAMR_CMD_MAX) ? `DAMR_EXC_VALUE :
                     `DAMR_EXC_NONE;
               `DAMR_A_SKIND, `DAMR_A_FAIL:
                  exc_c = `DAMR_EXC_NONE;
               default:
                  exc_c = `DAMR_EXC_ADDR;
            endcase
            wr_ok_c = (exc_c == `DAMR_EXC_NONE);
         end
         default:
            exc_c = `DAMR_EXC_FUNC;
      endcase
   end

   // Table read, word selected by reply byte index
   wire [7:0] widx = idx_q - 8'h03;
   wire [15:0] rd_addr = q_start + {9'h000, widx[7:1]};
   reg [15:0] rd_c;
   always @*
   begin
      case (rd_addr)
         `DAMR_A_SETPT: rd_c = setpt_q;
         `DAMR_A_OVR: rd_c = ovr_q;
         `DAMR_A_CMD: rd_c = SERVICE_CMD_O;
         `DAMR_A_TYPE: rd_c = ACT_TYPE_I;
         `DAMR_A_POS_REL: rd_c = POS_REL_I;
         `DAMR_A_POS_ABS: rd_c = POS_ABS_I;
         `DAMR_A_FLOW_REL: rd_c = FLOW_REL_I;
         `DAMR_A_FLOW_ABS: rd_c = FLOW_ABS_I;
         `DAMR_A_SENSOR: rd_c = SENSOR_I;
         `DAMR_A_SER1: rd_c = SER_PART1;
         `DAMR_A_SER2: rd_c = SER_PART2;
         `DAMR_A_SER4: rd_c = SER_PART4;
         `DAMR_A_FW: rd_c = FW_VERSION;
         `DAMR_A_FLAGS: rd_c = FAULT_FLAGS_I;
         `DAMR_A_LOWER: rd_c = lower_q;
         `DAMR_A_UPPER: rd_c = upper_q;
         `DAMR_A_SKIND: rd_c = SENSOR_KIND_O;
         `DAMR_A_FAIL: rd_c = FAIL_POS_O;
         default: rd_c = 16'h0000;
      endcase
   end

   // Reply byte for the current index
   reg [7:0] pay_c;
   always @*
   begin
      pay_c = 8'h00;
      if (idx_q == 8'h00)
         pay_c = q_addr;
      else if (idx_q == 8'h01)
         pay_c = (exc_q != `DAMR_EXC_NONE) ? (q_fc | `DAMR_EXC_FLAG) : q_fc;
      else if (exc_q != `DAMR_EXC_NONE)
         pay_c = exc_q;
      else if (q_fc == `DAMR_FC_WR_SINGLE)
         pay_c = buf_q[8'd63 - {idx_q[2:0], 3'h0} -: 8];
      else if (q_fc == `DAMR_FC_RD_BITS)
         pay_c = (idx_q == 8'h02) ? (len_q - 8'h03) :
            (idx_q == 8'h03) ? bits_q[7:0] : bits_q[15:8];
      else if (idx_q == 8'h02)
         pay_c = {q_val[6:0], 1'b0};
      else
         pay_c = widx[0] ? rd_c[7:0] : rd_c[15:8];
   end

   wire wr_hit = fend && cnt_q == `DAMR_REQ_LEN && rcrc_q == 16'h0000 &&
      (q_addr == SLAVE_ADDR_I || q_addr == `DAMR_BCAST) && wr_ok_c;

   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
         buf_q <= 64'h0;
         cnt_q <= 4'h0;
         rcrc_q <= `DAMR_CRC_INIT;
         tcrc_q <= `DAMR_CRC_INIT;
         gap_q <= 9'h000;
         st_q <= S_IDLE;
         idx_q <= 8'h00;
         len_q <= 8'h00;
         exc_q <= 8'h00;
         bits_q <= 16'h0000;
         tx_start_q <= 1'b0;
         tx_byte_q <= 8'h00;
         RS485_TX_O <= 1'b1;
         RS485_DRV_N_O <= 1'b1;
      end
      else
      begin
         tick_q <= (div_q == TDIV - 16'h0001);
         div_q <= (div_q == TDIV - 16'h0001) ? 16'h0000 : div_q + 16'h0001;
         RS485_TX_O <= tx_line;
         tx_start_q <= 1'b0;
         if (rx_valid || rx_busy)
            gap_q <= 9'h000;
         else if (tick_q && gap_q != `DAMR_GAP_TICKS)
            gap_q <= gap_q + 9'h001;
         // Own line ignored while answering
         if (rx_valid && st_q == S_IDLE)
         begin
            buf_q <= {buf_q[55:0], rx_data};
            if (cnt_q != 4'hf)
               cnt_q <= cnt_q + 4'h1;
            rcrc_q <= crc_upd(rcrc_q, rx_data);
         end
         if (fend)
         begin
            cnt_q <= 4'h0;
            rcrc_q <= `DAMR_CRC_INIT;
            // Broadcast is acted on but never answered
            if (cnt_q == `DAMR_REQ_LEN && rcrc_q == 16'h0000 &&
               q_addr == SLAVE_ADDR_I && st_q == S_IDLE)
            begin
               st_q <= S_SEND;
               RS485_DRV_N_O <= 1'b0;
               idx_q <= 8'h00;
               exc_q <= exc_c;
               tcrc_q <= `DAMR_CRC_INIT;
               bits_q <= FAULT_FLAGS_I >> bit_off[3:0] & bit_mask[15:0];
               if (exc_c != `DAMR_EXC_NONE)
                  len_q <= 8'h03;
               else if (q_fc == `DAMR_FC_WR_SINGLE)
                  len_q <= 8'h06;
               else if (q_fc == `DAMR_FC_RD_BITS)
                  len_q <= (q_val > 16'h0008) ? 8'h05 : 8'h04;
               else
                  len_q <= {q_val[6:0], 1'b0} + 8'h03;
            end
         end
         case (st_q)
            S_SEND:
            begin
               if (!tx_busy && !tx_start_q)
               begin
                  tx_start_q <= 1'b1;
                  idx_q <= idx_q + 8'h01;
                  if (idx_q < len_q)
                  begin
                     tx_byte_q <= pay_c;
                     tcrc_q <= crc_upd(tcrc_q, pay_c);
                  end
                  else if (idx_q == len_q)
                     tx_byte_q <= tcrc_q[7:0];
                  else
                  begin
                     tx_byte_q <= tcrc_q[15:8];
                     st_q <= S_DRAIN;
                  end
               end
            end
            S_DRAIN:
            begin
               if (!tx_busy && !tx_start_q)
               begin
                  st_q <= S_IDLE;
                  RS485_DRV_N_O <= 1'b1;
               end
            end
            S_IDLE:
            begin
               // Stays put so a frame end can start an answer
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   // Table storage, homing and target
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         setpt_q <= 16'h0000;
         ovr_q <= `DAMR_OVR_NONE;
         SERVICE_CMD_O <= 16'h0000;
         lower_q <= 16'h0000;
         upper_q <= `DAMR_FULL;
         SENSOR_KIND_O <= 16'h0000;
         FAIL_POS_O <= 16'h0000;
         NV_STORE_O <= 1'b0;
         NV_STORE_IDX_O <= 2'h0;
         NV_STORE_DATA_O <= 16'h0000;
         follow_q <= 1'b0;
         gear_prev_q <= 1'b0;
         HOMING_O <= 1'b1;
         HOME_CW_O <= 1'b0;
         TARGET_O <= 16'h0000;
         TARGET_VALID_O <= 1'b0;
      end
      else
      begin
         NV_STORE_O <= 1'b0;
         // Restored service values from non-volatile memory
         if (NV_LOAD_I)
         begin
            case (NV_LOAD_IDX_I)
               2'h0: lower_q <= NV_LOAD_DATA_I;
               2'h1: upper_q <= NV_LOAD_DATA_I;
               2'h2: SENSOR_KIND_O <= NV_LOAD_DATA_I;
               default: FAIL_POS_O <= NV_LOAD_DATA_I;
            endcase
         end
         // Bus write wins over a finished action in the same cycle
         if (wr_hit && q_start == `DAMR_A_CMD)
            SERVICE_CMD_O <= q_val;
         else if (CMD_DONE_I)
            SERVICE_CMD_O <= 16'h0000;
         if (wr_hit)
         begin
            case (q_start)
               `DAMR_A_SETPT: setpt_q <= q_val;
               `DAMR_A_OVR: ovr_q <= q_val;
               `DAMR_A_LOWER: lower_q <= q_val;
               `DAMR_A_UPPER: upper_q <= q_val;
               `DAMR_A_SKIND: SENSOR_KIND_O <= q_val;
               `DAMR_A_FAIL: FAIL_POS_O <= q_val;
               default: setpt_q <= setpt_q;
            endcase
            if (q_start >= `DAMR_A_LOWER)
            begin
               NV_STORE_O <= 1'b1;
               NV_STORE_IDX_O <= bit_off_nv(q_start);
               NV_STORE_DATA_O <= q_val;
            end
         end
         gear_prev_q <= pin_q[1];
         HOME_CW_O <= pin_q[0];
         if (pin_q[1] && !gear_prev_q)
            follow_q <= 1'b0;
         else if (!follow_q && pin_q[2])
            follow_q <= 1'b1;
         HOMING_O <= !follow_q;
         TARGET_VALID_O <= follow_q;
         if (follow_q)
         begin
            case (ovr_q)
               `DAMR_OVR_OPEN: TARGET_O <= `DAMR_FULL;
               `DAMR_OVR_CLOSE: TARGET_O <= 16'h0000;
               `DAMR_OVR_MIN: TARGET_O <= lower_q;
               `DAMR_OVR_MAX: TARGET_O <= upper_q;
               default: TARGET_O <= setpt_q;
            endcase
         end
      end
   end

   function [1:0] bit_off_nv;
      input [15:0] a;
      reg [15:0] d;
      begin
         d = a - `DAMR_A_LOWER;
         bit_off_nv = d[1:0];
      end
   endfunction
endmodule

// >>> damr_asserts.sv
// Port-level assertions for the damper actuator register block
module damr_asserts (
   // Clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // Pins watched
   input wire DIR_SWITCH_I,
   input wire END_STOP_I,
   input wire CMD_DONE_I,
   // Outputs watched
   input wire RS485_TX_O,
   input wire RS485_DRV_N_O,
   input wire HOMING_O,
   input wire HOME_CW_O,
   input wire [15:0] TARGET_O,
   input wire TARGET_VALID_O,
   input wire [15:0] SERVICE_CMD_O,
   input wire NV_STORE_O
);
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   a_home_first: assert property
      (TARGET_VALID_O |-> !HOMING_O) else $error("target while homing");
   a_home_side: assert property
      (DIR_SWITCH_I [*8] |-> HOME_CW_O == DIR_SWITCH_I)
      else $error("home side differs from switch");
   a_stop_ends_homing: assert property
      (END_STOP_I [*8] |-> !HOMING_O) else $error("homing not ended");
   a_follow_after: assert property
      ($fell(HOMING_O) |-> TARGET_VALID_O) else $error("no target");
   a_target_range: assert property
      (TARGET_VALID_O |-> TARGET_O <= 16'h2710) else $error("target high");
   a_cmd_clears: assert property
      (CMD_DONE_I |=> (RS485_DRV_N_O -> SERVICE_CMD_O == 16'h0000))
      else $error("command kept");
   a_store_pulse: assert property
      (NV_STORE_O |=> !NV_STORE_O) else $error("store not one cycle");
   a_store_answer: assert property
      (NV_STORE_O |-> ##[0:3] !RS485_DRV_N_O) else $error("store no answer");
   a_idle_line: assert property
      (RS485_DRV_N_O |-> RS485_TX_O) else $error("line low while idle");
   a_answer_holds: assert property
      ($fell(RS485_DRV_N_O) |-> !RS485_DRV_N_O [*8])
      else $error("answer cut short");
endmodule
bind damr_modbus_regs damr_asserts u_damr_asserts (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .DIR_SWITCH_I(DIR_SWITCH_I),
   .END_STOP_I(END_STOP_I), .CMD_DONE_I(CMD_DONE_I),
   .RS485_TX_O(RS485_TX_O), .RS485_DRV_N_O(RS485_DRV_N_O),
   .HOMING_O(HOMING_O), .HOME_CW_O(HOME_CW_O), .TARGET_O(TARGET_O),
   .TARGET_VALID_O(TARGET_VALID_O), .SERVICE_CMD_O(SERVICE_CMD_O),
   .NV_STORE_O(NV_STORE_O));

// >>> damr_mst.sv
// Modbus RTU master model on the half-duplex line
module damr_mst #(
   parameter int BIT = 16
) (
   // Clock
   input wire logic clk_i,
   // Line
   input wire logic line_i,
   output logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx [0:7];
   int rx_n;
   initial line_o = 1'b1;
   task automatic xf(input logic [7:0] dev, fc, input logic [15:0] a, v,
      input bit bad, input int nrx);
      logic [7:0] f [0:7];
      logic [15:0] c;
      logic [9:0] w;
      int t;
      f = '{dev, fc, a[15:8], a[7:0], v[15:8], v[7:0], 8'h00, 8'h00};
      c = 16'hffff;
      for (int i = 0; i < 6; i++)
      begin
         c = c ^ {8'h00, f[i]};
         for (int j = 0; j < 8; j++)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      // Low byte first; bad flips one bit to force a refusal
      {f[7], f[6]} = c ^ {15'h0, bad};
      for (int i = 0; i < 8; i++)
      begin
         w = {1'b1, f[i], 1'b0};
         for (int b = 0; b < 10; b++)
         begin
            @(posedge clk_i);
            #1 line_o = w[b];
            repeat (BIT - 1) @(posedge clk_i);
         end
      end
      rx = '{default: 8'hxx};
      rx_n = 0;
      while (rx_n < nrx)
      begin
         t = 0;
         while (line_i && t < 40 * BIT)
         begin
            @(posedge clk_i);
            t++;
         end
         if (line_i)
            break;
         repeat (BIT + BIT / 2) @(posedge clk_i);
         for (int b = 0; b < 8; b++)
         begin
            rx[rx_n][b] = line_i;
            repeat (BIT) @(posedge clk_i);
         end
         rx_n++;
      end
      repeat (36 * BIT) @(posedge clk_i);
      #1;
   endtask
endmodule

// >>> damr_modbus_regs_test.sv
// Self-checking bench of the damper actuator Modbus register block
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("FAIL %0t got %h want %h", $time, g, e); \
      end \
   end
module damr_modbus_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BAUD = 6250000;
   localparam logic [7:0] ADDR = 8'h11;
   // Function, address, value, reply index, expected word
   logic [59:0] rows [0:14] = '{
      60'h06_0000_1388_4_1388,
      60'h03_0000_0001_3_1388,
      60'h04_0005_0001_3_33c5,
      60'h03_0006_0001_3_43c5,
      60'h03_0008_0001_3_63c5,
      60'h03_0066_0001_3_4444,
      60'h03_0068_0001_3_73c5,
      60'h02_0680_0010_3_c573,
      60'h06_0069_0064_4_0064,
      60'h06_0003_0001_1_8602,
      60'h06_0000_2711_1_8603,
      60'h06_0001_0004_1_8603,
      60'h06_0002_0005_1_8603,
      60'h03_0009_0001_1_8302,
      60'h06_006b_0002_4_0002
   };
   logic [15:0] ovr [0:4] = '{16'h1, 16'h2, 16'h3, 16'h5, 16'h0};
   logic [15:0] ovr_t [0:4] = '{16'h2710, 16'h0, 16'h64, 16'h2710, 16'h1388};
   logic clk, rst_n, dir, gear, stop, done, nv_ld, m_line;
   logic [15:0] live [0:6];
   logic [7:0] fc;
   logic [15:0] a, v, e;
   logic [3:0] k;
   logic [17:0] nv_cap;
   int miscompares, tests_run, nv_n;
   wire tx, drv_n, hom, cw, tv, bus, nv_st;
   wire [15:0] tgt, cmd, fail, kind, nv_dat;
   wire [1:0] nv_idx;
   // Idle bias holds the released line high
   assign bus = drv_n ? 1'b1 : tx;
   damr_mst #(.BIT(100000000 / BAUD)) u_damr_mst (.clk_i(clk),
      .line_i(bus), .line_o(m_line));
   damr_modbus_regs #(.BAUD(BAUD)) u_damr_modbus_regs (
      .CLK_I(clk), .RESET_N_I(rst_n), .RS485_RX_I(m_line), .RS485_TX_O(tx),
      .RS485_DRV_N_O(drv_n), .SLAVE_ADDR_I(ADDR), .DIR_SWITCH_I(dir),
      .GEAR_RELEASE_I(gear), .END_STOP_I(stop), .ACT_TYPE_I(live[0]),
      .POS_REL_I(live[1]), .POS_ABS_I(live[2]), .FLOW_REL_I(live[3]),
      .FLOW_ABS_I(live[4]), .SENSOR_I(live[5]), .FAULT_FLAGS_I(live[6]),
      .CMD_DONE_I(done), .HOMING_O(hom), .HOME_CW_O(cw), .TARGET_O(tgt),
      .TARGET_VALID_O(tv), .SERVICE_CMD_O(cmd), .SENSOR_KIND_O(kind),
      .FAIL_POS_O(fail), .NV_STORE_O(nv_st), .NV_STORE_IDX_O(nv_idx),
      .NV_STORE_DATA_O(nv_dat), .NV_LOAD_I(nv_ld), .NV_LOAD_IDX_I(2'h3),
      .NV_LOAD_DATA_I(16'h0007));
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic step(ref logic s);
      s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_hom(input logic w);
      for (int n = 0; n < 100 && hom !== w; n++)
         @(posedge clk);
      #1;
      `CHK(hom, w)
      if (hom !== w)
         close_out();
   endtask
   // Stores seen on the non-volatile port
   always @(posedge clk)
      if (nv_st)
      begin
         nv_n <= nv_n + 1;
         nv_cap <= {nv_idx, nv_dat};
      end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rst_n, dir, gear, stop, done, nv_ld} = '0;
      foreach (live[i])
         live[i] = {4'(i + 1), 12'h3c5};
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      `CHK({hom, tv, cw}, 3'b100)
      foreach (rows[i])
      begin
         {fc, a, v, k, e} = rows[i];
         u_damr_mst.xf(ADDR, fc, a, v, 1'b0, k + 4);
         `CHK({u_damr_mst.rx[k], u_damr_mst.rx[k + 1]}, e)
      end
      `CHK(nv_n, 2)
      `CHK({kind, nv_cap}, {16'h0002, 2'h2, 16'h0002})
      $display("table test done");
      dir = 1'b1;
      stop = 1'b1;
      wait_hom(1'b0);
      `CHK({cw, tv, tgt}, {2'b11, 16'h1388})
      foreach (ovr[i])
      begin
         u_damr_mst.xf(ADDR, 8'h06, 16'h0001, ovr[i], 1'b0, 8);
         `CHK(tgt, ovr_t[i])
      end
      for (int c = 1; c < 5; c++)
      begin
         u_damr_mst.xf(ADDR, 8'h06, 16'h0002, 16'(c), 1'b0, 8);
         `CHK(cmd, 16'(c))
         step(done);
         `CHK(cmd, 16'h0000)
      end
      for (int b = 0; b < 2; b++)
      begin
         // Corrupt check word, then a foreign slave address
         u_damr_mst.xf(ADDR + 8'(b), 8'h03, 16'h0, 16'h1, b == 0, 1);
         `CHK(u_damr_mst.rx_n, 0)
      end
      step(nv_ld);
      `CHK(fail, 16'h0007)
      stop = 1'b0;
      gear = 1'b1;
      wait_hom(1'b1);
      `CHK(tv, 1'b0)
      $display("hand tests done");
      // Reset in mid-run; operating values are not retained
      rst_n = 1'b0;
      gear = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK({hom, tv, drv_n, tx, tgt, cmd, fail}, {4'b1011, 48'h0})
      rst_n = 1'b1;
      stop = 1'b1;
      wait_hom(1'b0);
      `CHK({tv, tgt}, {1'b1, 16'h0000})
      $display("reset test done");
      close_out();
   end
endmodule
